// >>> design/pmr_pkg.sv
// Shared constants, types and register map of the PHY management register set
package pmr_pkg;

  localparam logic [9:0] ADDR_CTRL = 10'h040;
  localparam logic [9:0] ADDR_STAT = 10'h041;
  localparam logic [9:0] ADDR_ID_HI = 10'h042;
  localparam logic [9:0] ADDR_ID_LO = 10'h043;
  localparam logic [9:0] ADDR_ADV = 10'h044;
  localparam logic [9:0] ADDR_LPA = 10'h045;

  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [4:0] HDR_LAST = 5'h0B;
  localparam logic [4:0] TA_LAST = 5'h01;
  localparam logic [4:0] DATA_LAST = 5'h0F;

  localparam int CTL_RST = 15;
  localparam int CTL_LOOP = 14;
  localparam int CTL_SPEED = 13;
  localparam int CTL_AN_EN = 12;
  localparam int CTL_PDN = 11;
  localparam int CTL_RESTART = 9;
  localparam int CTL_DUPLEX = 8;
  localparam int ADV_RF = 13;
  localparam int ADV_PAUSE = 10;
  localparam int LP_ACK = 14;
  localparam int LP_RF = 13;

  localparam logic [4:0] STAT_CAPS = 5'h0F;
  localparam logic [3:0] ADV_ABIL_DFLT = 4'hF;
  localparam logic [4:0] SEL_CSMA = 5'h01;

  localparam logic [4:0] SRST_CYCLES = 5'h10;
  localparam logic [1:0] STRAP_TAP = 2'h2;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned DEAD_TIME_MS = 720;
  localparam int unsigned DEAD_CYCLES = DEAD_TIME_MS * 1000000 / CLK_PERIOD_NS;

  typedef struct packed {
    logic srst;
    logic loop;
    logic speed;
    logic an_en;
    logic pdn;
    logic restart;
    logic duplex;
  } pmr_ctl_s;

  localparam pmr_ctl_s CTL_DFLT = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

  typedef struct packed {
    logic rf;
    logic pause;
    logic [3:0] abil;
    logic [4:0] sel;
  } pmr_adv_s;

  typedef enum logic [4:0] {
    FR_IDLE = 5'h01,
    FR_START = 5'h02,
    FR_HDR = 5'h04,
    FR_TA = 5'h08,
    FR_DATA = 5'h10
  } pmr_frame_e;

  typedef enum logic [3:0] {
    AN_OFF = 4'h1,
    AN_ABIL = 4'h2,
    AN_ACK = 4'h4,
    AN_DONE = 4'h8
  } pmr_an_e;

endpackage

// >>> design/pmr_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module pmr_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// >>> design/pmr_an.sv
// Auto-negotiation sequencer: partner capture, acknowledge and resolution
`timescale 1ns/100ps
module pmr_an (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic en,
  input wire logic clr,
  input wire logic restart,
  input wire logic link_ok,
  input wire logic lp_valid,
  input wire logic [15:0] lp_word,
  input wire logic [3:0] adv_abil,
  output logic start_ack,
  output logic done,
  output logic ack,
  output logic res100,
  output logic resfdx,
  output logic [15:0] lp
);
  pmr_pkg::pmr_an_e st_r, st_nxt;
  logic start_nxt, done_nxt, ack_nxt, r100_nxt, rfdx_nxt;
  logic [15:0] lp_nxt;
  logic [3:0] common;

  assign common = adv_abil & lp_word[8:5];

  always_comb begin
    st_nxt = st_r;
    start_nxt = 1'b0;
    done_nxt = done;
    ack_nxt = ack;
    lp_nxt = lp;
    r100_nxt = res100;
    rfdx_nxt = resfdx;
    if (!en) begin
      st_nxt = pmr_pkg::AN_OFF;
      done_nxt = 1'b0;
      ack_nxt = 1'b0;
      if (clr) begin
        lp_nxt = '0;
        r100_nxt = 1'b0;
        rfdx_nxt = 1'b0;
      end
    end else if (restart && !start_ack) begin
      // A restart is taken once; clearing the request later does not stop the run
      st_nxt = pmr_pkg::AN_ABIL;
      start_nxt = 1'b1;
      done_nxt = 1'b0;
      ack_nxt = 1'b0;
    end else begin
      unique case (st_r)
        pmr_pkg::AN_OFF: st_nxt = pmr_pkg::AN_ABIL;
        pmr_pkg::AN_ABIL: begin
          if (lp_valid) begin
            lp_nxt = lp_word;
            ack_nxt = 1'b1;
            st_nxt = pmr_pkg::AN_ACK;
          end
        end
        pmr_pkg::AN_ACK: begin
          if (lp_valid && lp_word[pmr_pkg::LP_ACK]) begin
            lp_nxt = lp_word;
            r100_nxt = |common[3:2];
            rfdx_nxt = common[3] | (!common[2] & common[1]);
            done_nxt = 1'b1;
            st_nxt = pmr_pkg::AN_DONE;
          end
        end
        pmr_pkg::AN_DONE: begin
          if (!link_ok) begin
            st_nxt = pmr_pkg::AN_ABIL;
            done_nxt = 1'b0;
            ack_nxt = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= pmr_pkg::AN_OFF;
      start_ack <= 1'b0;
      done <= 1'b0;
      ack <= 1'b0;
      lp <= '0;
      res100 <= 1'b0;
      resfdx <= 1'b0;
    end else begin
      st_r <= st_nxt;
      start_ack <= start_nxt;
      done <= done_nxt;
      ack <= ack_nxt;
      lp <= lp_nxt;
      res100 <= r100_nxt;
      resfdx <= rfdx_nxt;
    end
  end
endmodule

// >>> design/pmr_phy_regs.sv
// PHY management register set with serial management slave
// Operation
// - Writing control bit 15 resets registers; bit reads one until reset ends.
// - Control bit 14 enables loopback; at 100M a 720ms receive dead time follows.
// - Control bit 13 picks 100M; with negotiation on it reads resolved speed.
// - Control bit 12 enables negotiation; bits 13 and 8 then show result.
// - Control bit 11 powers down; management still answers, negotiation halts, other outputs keep driving.
// - Control bit 9 restarts negotiation, self-clears once started, ignored if disabled.
// - Clearing restart during negotiation leaves the running process undisturbed.
// - Control bit 8 selects full duplex, effective only with negotiation off.
// - Status reports fixed capabilities: no T4, TX/10T both duplexes, AN, extended.
// - Status bit 6 reads one: preamble-suppressed management frames are accepted.
// - Status bit 5 reads one when negotiation has completed.
// - Status bit 4 sets on partner remote fault; clears on read or reset.
// - Status bit 2 shows link; latched low until status is read.
// - Status bit 1 flags jabber, detected only at 10M.
// - First identifier register holds organisation code bits 3 to 18.
// - Second identifier: organisation bits 19-24, model, revision; read-only.
// - Advertisement next page and T4 bits always read zero.
// - Advertisement acknowledge bit is driven by the negotiation sequencer.
// - Advertisement selector defaults to 00001 and is writable.
// - Advertisement bits 8-5 writable, default one; bit 13 fault, 10 pause.
// - Partner register captures next page, acknowledge and remote fault, read-only.
// - Pause advertisement default is the inverted strap pin sampled at power-up.
// - All control and status registers return to defaults on any reset.
`timescale 1ns/100ps
module pmr_phy_regs #(
  parameter int unsigned DEAD_CYC = pmr_pkg::DEAD_CYCLES,
  parameter logic [15:0] ORG_CODE_UPPER = 16'h5A3C, // arbitrary value
  parameter logic [5:0] ORG_CODE_LOWER = 6'h2D, // arbitrary value
  parameter logic [5:0] MODEL_NUM = 6'h15, // arbitrary value
  parameter logic [3:0] MODEL_REV = 4'h7 // arbitrary value
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic smi_ck,
  input wire logic smi_dio_i,
  input wire logic pause_strap_pin,
  input wire logic link_ok,
  input wire logic jabber,
  input wire logic lp_valid,
  input wire logic [15:0] lp_word,
  output logic smi_dio_o,
  output logic smi_dio_oe_n,
  output logic speed_100_o,
  output logic full_dup_o,
  output logic loopback_o,
  output logic power_down_o,
  output logic rx_dead_o,
  output logic an_done_o
);
  logic [2:0] sync_q;
  logic ck_s, dio_s, strap_s, ck_d_r, rise, fall;

  pmr_sync #(.W(3)) u_sync (
    .clk(mclk),
    .arst_n(arst_n),
    .d({smi_ck, smi_dio_i, pause_strap_pin}),
    .q(sync_q)
  );
  assign ck_s = sync_q[2];
  assign dio_s = sync_q[1];
  assign strap_s = sync_q[0];
  assign rise = ck_s & ~ck_d_r;
  assign fall = ~ck_s & ck_d_r;

  // Serial frame: start 01, op, 10-bit address, turnaround, 16 data bits
  pmr_pkg::pmr_frame_e fr_r, fr_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [11:0] hdr_r, hdr_nxt, hdr_sh;
  logic [15:0] wsh_r, wsh_nxt, rsh_r, rsh_nxt;
  logic rd_r, rd_nxt, dio_r, dio_nxt, oe_n_r, oe_n_nxt;
  logic hit, rd_stb, wr_stb;
  logic [15:0] rd_word;
  logic [9:0] addr;

  assign hdr_sh = {hdr_r[10:0], dio_s};
  // Shifter on the last header bit, held header after it; avoids a loop through the frame logic
  assign addr = (fr_r == pmr_pkg::FR_HDR) ? hdr_sh[9:0] : hdr_r[9:0];
  assign hit = (addr >= pmr_pkg::ADDR_CTRL) && (addr <= pmr_pkg::ADDR_LPA);

  always_comb begin
    fr_nxt = fr_r;
    cnt_nxt = cnt_r;
    hdr_nxt = hdr_r;
    wsh_nxt = wsh_r;
    rsh_nxt = rsh_r;
    rd_nxt = rd_r;
    dio_nxt = dio_r;
    oe_n_nxt = oe_n_r;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    if (rise) begin
      unique case (fr_r)
        // No preamble is demanded, so suppressed-preamble frames work
        pmr_pkg::FR_IDLE: if (!dio_s) fr_nxt = pmr_pkg::FR_START;
        pmr_pkg::FR_START: begin
          if (dio_s) begin
            fr_nxt = pmr_pkg::FR_HDR;
            cnt_nxt = '0;
          end
        end
        pmr_pkg::FR_HDR: begin
          hdr_nxt = hdr_sh;
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == pmr_pkg::HDR_LAST) begin
            cnt_nxt = '0;
            rd_nxt = (hdr_nxt[11:10] == pmr_pkg::OP_RD) && hit;
            rd_stb = rd_nxt;
            rsh_nxt = rd_word;
            fr_nxt = (hdr_nxt[11:10] == pmr_pkg::OP_RD || hdr_nxt[11:10] == pmr_pkg::OP_WR)
                     ? pmr_pkg::FR_TA : pmr_pkg::FR_IDLE;
          end
        end
        pmr_pkg::FR_TA: begin
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == pmr_pkg::TA_LAST) begin
            cnt_nxt = '0;
            fr_nxt = pmr_pkg::FR_DATA;
          end
        end
        pmr_pkg::FR_DATA: begin
          wsh_nxt = {wsh_r[14:0], dio_s};
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == pmr_pkg::DATA_LAST) begin
            wr_stb = !rd_r && (hdr_r[11:10] == pmr_pkg::OP_WR) && hit;
            fr_nxt = pmr_pkg::FR_IDLE;
          end
        end
      endcase
    end
    if (fall) begin
      if (fr_r == pmr_pkg::FR_TA && cnt_r == pmr_pkg::TA_LAST && rd_r) begin
        oe_n_nxt = 1'b0;
        dio_nxt = 1'b0;
      end else if (fr_r == pmr_pkg::FR_DATA && rd_r) begin
        dio_nxt = rsh_r[15];
        rsh_nxt = {rsh_r[14:0], 1'b0};
      end else if (fr_r == pmr_pkg::FR_IDLE) begin
        oe_n_nxt = 1'b1;
        dio_nxt = 1'b1;
        rd_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ck_d_r <= 1'b0;
      fr_r <= pmr_pkg::FR_IDLE;
      cnt_r <= '0;
      hdr_r <= '0;
      wsh_r <= '0;
      rsh_r <= '0;
      rd_r <= 1'b0;
      dio_r <= 1'b1;
      oe_n_r <= 1'b1;
    end else begin
      ck_d_r <= ck_s;
      fr_r <= fr_nxt;
      cnt_r <= cnt_nxt;
      hdr_r <= hdr_nxt;
      wsh_r <= wsh_nxt;
      rsh_r <= rsh_nxt;
      rd_r <= rd_nxt;
      dio_r <= dio_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end
  assign smi_dio_o = dio_r;
  assign smi_dio_oe_n = oe_n_r;

  // Register state
  pmr_pkg::pmr_ctl_s ctl_r, ctl_nxt;
  pmr_pkg::pmr_adv_s adv_r, adv_nxt;
  logic rf_r, rf_nxt, link_r, link_nxt, jab_r, jab_nxt, lp_rf_d_r, rf_set;
  logic pause_dflt_r, pause_dflt_nxt, spd_r, spd_nxt, dup_r, dup_nxt, loop_d_r, dead_r, dead_nxt;
  logic [1:0] strap_cnt_r, strap_cnt_nxt;
  logic [4:0] srst_cnt_r, srst_cnt_nxt;
  logic [23:0] dead_cnt_r, dead_cnt_nxt;
  logic an_start, an_done, an_ack, an_r100, an_rfdx, wr_ctl;
  logic [15:0] an_lp, wd;

  pmr_an u_an (
    .clk(mclk),
    .arst_n(arst_n),
    .en(ctl_r.an_en & ~ctl_r.pdn & ~ctl_r.srst),
    .clr(ctl_r.srst),
    .restart(ctl_r.restart),
    .link_ok(link_ok),
    .lp_valid(lp_valid),
    .lp_word(lp_word),
    .adv_abil(adv_r.abil),
    .start_ack(an_start),
    .done(an_done),
    .ack(an_ack),
    .res100(an_r100),
    .resfdx(an_rfdx),
    .lp(an_lp)
  );

  assign rf_set = an_lp[pmr_pkg::LP_RF] & ~lp_rf_d_r;
  assign wd = wsh_nxt;
  assign wr_ctl = wr_stb && hdr_r[9:0] == pmr_pkg::ADDR_CTRL;

  always_comb begin
    unique case (addr)
      pmr_pkg::ADDR_CTRL: rd_word = {ctl_r.srst, ctl_r.loop, spd_r, ctl_r.an_en, ctl_r.pdn, 1'b0,
                                     ctl_r.restart, dup_r, 8'h00};
      pmr_pkg::ADDR_STAT: rd_word = {pmr_pkg::STAT_CAPS, 4'h0, 1'b1, an_done, rf_r, 1'b1, link_r, jab_r,
                                     1'b1};
      pmr_pkg::ADDR_ID_HI: rd_word = ORG_CODE_UPPER;
      pmr_pkg::ADDR_ID_LO: rd_word = {ORG_CODE_LOWER, MODEL_NUM, MODEL_REV};
      pmr_pkg::ADDR_ADV: rd_word = {1'b0, an_ack, adv_r.rf, 2'h0, adv_r.pause, 1'b0, adv_r.abil,
                                    adv_r.sel};
      pmr_pkg::ADDR_LPA: rd_word = {an_lp[15:13], 2'h0, an_lp[10:0]};
      default: rd_word = 16'h0000;
    endcase
  end

  always_comb begin
    ctl_nxt = ctl_r;
    adv_nxt = adv_r;
    rf_nxt = rf_r;
    link_nxt = link_r & link_ok;
    jab_nxt = jab_r | (jabber & ~spd_r);
    pause_dflt_nxt = pause_dflt_r;
    strap_cnt_nxt = strap_cnt_r;
    srst_cnt_nxt = srst_cnt_r;
    if (strap_cnt_r != 2'h3) strap_cnt_nxt = strap_cnt_r + 2'h1;
    if (strap_cnt_r == pmr_pkg::STRAP_TAP) begin
      pause_dflt_nxt = ~strap_s;
      adv_nxt.pause = ~strap_s;
    end
    // A read wins over nothing: a new fault in the same cycle still sets
    if (rd_stb && addr == pmr_pkg::ADDR_STAT) begin
      rf_nxt = 1'b0;
      jab_nxt = jabber & ~spd_r;
      link_nxt = link_ok;
    end
    if (rf_set) rf_nxt = 1'b1;
    if (an_start) ctl_nxt.restart = 1'b0;
    if (ctl_r.srst) begin
      srst_cnt_nxt = srst_cnt_r - 5'h01;
      if (srst_cnt_r == 5'h01) ctl_nxt.srst = 1'b0;
    end else if (wr_ctl && wd[pmr_pkg::CTL_RST]) begin
      ctl_nxt = pmr_pkg::CTL_DFLT;
      ctl_nxt.srst = 1'b1;
      srst_cnt_nxt = pmr_pkg::SRST_CYCLES;
      adv_nxt = '{1'b0, pause_dflt_r, pmr_pkg::ADV_ABIL_DFLT, pmr_pkg::SEL_CSMA};
      rf_nxt = 1'b0;
      link_nxt = 1'b0;
      jab_nxt = 1'b0;
    end else if (wr_ctl) begin
      ctl_nxt.loop = wd[pmr_pkg::CTL_LOOP];
      ctl_nxt.speed = wd[pmr_pkg::CTL_SPEED];
      ctl_nxt.an_en = wd[pmr_pkg::CTL_AN_EN];
      ctl_nxt.pdn = wd[pmr_pkg::CTL_PDN];
      ctl_nxt.duplex = wd[pmr_pkg::CTL_DUPLEX];
      // Writing zero drops only the request; a started run goes on
      ctl_nxt.restart = wd[pmr_pkg::CTL_RESTART] & wd[pmr_pkg::CTL_AN_EN];
    end else if (wr_stb && hdr_r[9:0] == pmr_pkg::ADDR_ADV) begin
      adv_nxt = '{wd[pmr_pkg::ADV_RF], wd[pmr_pkg::ADV_PAUSE], wd[8:5], wd[4:0]};
    end
    if (!ctl_nxt.an_en) ctl_nxt.restart = 1'b0;
  end

  // Effective mode follows negotiation when enabled, else the manual bits
  always_comb begin
    spd_nxt = ctl_r.an_en ? an_r100 : ctl_r.speed;
    dup_nxt = ctl_r.an_en ? an_rfdx : ctl_r.duplex;
    dead_cnt_nxt = dead_cnt_r;
    if (ctl_r.loop && !loop_d_r && spd_r) begin
      dead_cnt_nxt = DEAD_CYC[23:0];
    end else if (dead_cnt_r != 24'h000000) begin
      dead_cnt_nxt = dead_cnt_r - 24'h000001;
    end
    dead_nxt = dead_cnt_nxt != 24'h000000;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_r <= pmr_pkg::CTL_DFLT;
      adv_r <= '{1'b0, 1'b1, pmr_pkg::ADV_ABIL_DFLT, pmr_pkg::SEL_CSMA};
      rf_r <= 1'b0;
      link_r <= 1'b0;
      jab_r <= 1'b0;
      lp_rf_d_r <= 1'b0;
      pause_dflt_r <= 1'b1;
      strap_cnt_r <= '0;
      srst_cnt_r <= '0;
      spd_r <= 1'b0;
      dup_r <= 1'b0;
      loop_d_r <= 1'b0;
      dead_cnt_r <= '0;
      dead_r <= 1'b0;
    end else begin
      ctl_r <= ctl_nxt;
      adv_r <= adv_nxt;
      rf_r <= rf_nxt;
      link_r <= link_nxt;
      jab_r <= jab_nxt;
      lp_rf_d_r <= an_lp[pmr_pkg::LP_RF];
      pause_dflt_r <= pause_dflt_nxt;
      strap_cnt_r <= strap_cnt_nxt;
      srst_cnt_r <= srst_cnt_nxt;
      spd_r <= spd_nxt;
      dup_r <= dup_nxt;
      loop_d_r <= ctl_r.loop;
      dead_cnt_r <= dead_cnt_nxt;
      dead_r <= dead_nxt;
    end
  end

  assign speed_100_o = spd_r;
  assign full_dup_o = dup_r;
  assign loopback_o = ctl_r.loop;
  assign power_down_o = ctl_r.pdn;
  assign rx_dead_o = dead_r;
  assign an_done_o = an_done;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_srst_end;
    $rose(ctl_r.srst) |-> ctl_r.srst[*8] ##[1:12] !ctl_r.srst;
  endproperty
  a_srst_end: assert property (p_srst_end) else $error("soft reset length wrong");
  property p_restart_gated;
    ctl_r.restart |-> ctl_r.an_en;
  endproperty
  a_restart_gated: assert property (p_restart_gated) else $error("restart pending while disabled");
  property p_restart_clear;
    $rose(ctl_r.restart) && !ctl_r.pdn |-> ##[1:4] !ctl_r.restart;
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("restart did not self-clear");
  property p_an_speed;
    ctl_r.an_en |=> spd_r == $past(an_r100);
  endproperty
  a_an_speed: assert property (p_an_speed) else $error("speed not from negotiation");
  property p_man_dup;
    !ctl_r.an_en |=> dup_r == $past(ctl_r.duplex);
  endproperty
  a_man_dup: assert property (p_man_dup) else $error("manual duplex not applied");
  property p_link_latch;
    !link_ok && !rd_stb |=> !link_r;
  endproperty
  a_link_latch: assert property (p_link_latch) else $error("link failure not latched");
  property p_rf_set;
    rf_set && !(wr_ctl && wd[pmr_pkg::CTL_RST]) |=> rf_r;
  endproperty
  a_rf_set: assert property (p_rf_set) else $error("remote fault lost");
  property p_jab_10;
    $rose(jab_r) |-> $past(!spd_r && jabber);
  endproperty
  a_jab_10: assert property (p_jab_10) else $error("jabber at 100M");
  property p_strap;
    strap_cnt_r == pmr_pkg::STRAP_TAP |=> adv_r.pause == !$past(strap_s);
  endproperty
  a_strap: assert property (p_strap) else $error("pause default not from strap");

  c_srst: cover property ($rose(ctl_r.srst));
  c_read: cover property (rd_stb ##[1:300] !oe_n_r);
  c_an_done: cover property ($rose(an_done));
endmodule

// >>> tb/pmr_host_model.sv
// Host-side serial management master that frames reads and writes
`timescale 1ns/100ps
module pmr_host_model (
  input wire logic mclk,
  input wire logic dio_i,
  output logic smi_ck,
  output logic dio_o,
  output logic dio_en
);
  // Clock stands low between frames
  initial begin
    smi_ck = 1'b0;
    dio_o = 1'b1;
    dio_en = 1'b0;
  end

  // Data changes while the clock is low; the device is sampled just before the fall,
  // where its bit has stood longest
  task automatic bit_cyc(input logic b, input logic drv, output logic s);
    dio_o <= b;
    dio_en <= drv;
    repeat (4) @(posedge mclk);
    smi_ck <= 1'b1;
    repeat (4) @(posedge mclk);
    s = dio_i;
    smi_ck <= 1'b0;
  endtask

  task automatic xfer(input int idle, input logic [1:0] op, input logic [9:0] a, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [31:0] f;
    logic s;
    f = {2'b01, op, a, 2'b10, wd};
    rd = 16'h0;
    repeat (idle) bit_cyc(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      bit_cyc(f[i], !(op == pmr_pkg::OP_RD && i < 18), s);
      if (i < 16) rd[i] = s;
    end
    dio_en <= 1'b0;
    @(posedge mclk);
  endtask
endmodule

// >>> tb/pmr_phy_regs_tb_top.sv
// Self-checking bench for the PHY management register set
`timescale 1ns/100ps
module pmr_phy_regs_tb_top;
  localparam logic [15:0] ID_HI = 16'h1234; // Arbitrary value
  localparam logic [15:0] ID_LO = {6'h2A, 6'h0C, 4'h3}; // Arbitrary value
  logic mclk, arst_n, pause_strap_pin, link_ok, jabber, lp_valid;
  logic [15:0] lp_word, rd_word, w;
  logic smi_ck, h_o, h_en, dut_o, oe_n, dio_w, rd_stb;
  logic spd, dup, loop_o, pdn, dead, done;
  int n_fail, cmp_count;
  logic [15:0] exp_q[$];
  string nm_q[$];

  // Pin has a pull-down, so a released line reads low
  assign dio_w = !oe_n ? dut_o : (h_en ? h_o : 1'b0);

  pmr_phy_regs #(.DEAD_CYC(50), .ORG_CODE_UPPER(ID_HI), .ORG_CODE_LOWER(ID_LO[15:10]),
    .MODEL_NUM(ID_LO[9:4]), .MODEL_REV(ID_LO[3:0])) dut (.mclk(mclk), .arst_n(arst_n), .smi_ck(smi_ck),
    .smi_dio_i(dio_w), .pause_strap_pin(pause_strap_pin), .link_ok(link_ok), .jabber(jabber),
    .lp_valid(lp_valid), .lp_word(lp_word), .smi_dio_o(dut_o), .smi_dio_oe_n(oe_n), .speed_100_o(spd),
    .full_dup_o(dup), .loopback_o(loop_o), .power_down_o(pdn), .rx_dead_o(dead), .an_done_o(done));
  pmr_host_model host (.mclk(mclk), .dio_i(dio_w), .smi_ck(smi_ck), .dio_o(h_o), .dio_en(h_en));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    logic [15:0] x;
    @(posedge mclk);
    host.xfer(2, pmr_pkg::OP_WR, a, d, x);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask

  // Expected value is queued before the frame; the monitor pairs it with the answer
  task automatic rd(input string nm, input logic [9:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF,
                    input int idle = 2);
    logic [15:0] d;
    @(posedge mclk);
    nm_q.push_back(nm);
    exp_q.push_back(e);
    host.xfer(idle, pmr_pkg::OP_RD, a, 16'h0, d);
    rd_word <= d & m;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
  endtask

  always @(posedge mclk) begin
    if (rd_stb === 1'b1) check(nm_q.pop_front(), rd_word, exp_q.pop_front());
  end

  task automatic lp_pulse(input logic [15:0] v);
    @(posedge mclk);
    lp_word <= v;
    lp_valid <= 1'b1;
    @(posedge mclk);
    lp_valid <= 1'b0;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic jab();
    @(posedge mclk);
    jabber <= 1'b1;
    @(posedge mclk);
    jabber <= 1'b0;
  endtask

  initial begin
    arst_n = 1'b0;
    pause_strap_pin = 1'b1;
    link_ok = 1'b1;
    jabber = 1'b0;
    lp_valid = 1'b0;
    lp_word = 16'h0;
    rd_stb = 1'b0;
    rd_word = 16'h0;
    n_fail = 0;
    cmp_count = 0;
    void'($urandom(32'hAB67));
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    rd("ctrl_dflt", pmr_pkg::ADDR_CTRL, 16'h1000, 16'hFFFF, 0);
    rd("stat_dflt", pmr_pkg::ADDR_STAT, 16'h7849, 16'hFFFB);
    rd("stat_link", pmr_pkg::ADDR_STAT, 16'h784D);
    @(posedge mclk);
    link_ok <= 1'b0;
    repeat (3) @(posedge mclk);
    link_ok <= 1'b1;
    rd("link_latched", pmr_pkg::ADDR_STAT, 16'h7849);
    rd("link_rearm", pmr_pkg::ADDR_STAT, 16'h784D);
    jab();
    rd("jabber_10m", pmr_pkg::ADDR_STAT, 16'h784F);
    rd("jabber_clr", pmr_pkg::ADDR_STAT, 16'h784D);
    rd("id_hi", pmr_pkg::ADDR_ID_HI, ID_HI);
    wr(pmr_pkg::ADDR_ID_HI, 16'hFFFF);
    rd("id_hi_ro", pmr_pkg::ADDR_ID_HI, ID_HI);
    wr(pmr_pkg::ADDR_ID_LO, 16'h0000);
    rd("id_lo", pmr_pkg::ADDR_ID_LO, ID_LO);
    rd("adv_dflt", pmr_pkg::ADDR_ADV, 16'h01E1);
    rd("lpa_dflt", pmr_pkg::ADDR_LPA, 16'h0000);
    rd("unmapped", 10'h046, 16'h0000);
    // Acknowledge bit stays clear in what we write
    for (int i = 0; i < 3; i++) begin
      w = 16'($urandom()) & 16'hA7FF;
      wr(pmr_pkg::ADDR_ADV, w);
      rd("adv_rw", pmr_pkg::ADDR_ADV, w & 16'h25FF);
    end
    wr(pmr_pkg::ADDR_ADV, 16'h01E1);
    lp_pulse(16'h61E0);
    lp_pulse(16'h61E0);
    check("an_done", 16'(done), 16'h1);
    check("an_speed", 16'(spd), 16'h1);
    check("an_dup", 16'(dup), 16'h1);
    rd("ctrl_an", pmr_pkg::ADDR_CTRL, 16'h3100);
    rd("stat_an", pmr_pkg::ADDR_STAT, 16'h787D);
    rd("rf_clr", pmr_pkg::ADDR_STAT, 16'h786D);
    rd("adv_ack", pmr_pkg::ADDR_ADV, 16'h41E1);
    rd("lpa_cap", pmr_pkg::ADDR_LPA, 16'h6000, 16'hE000);
    jab();
    rd("jabber_100m", pmr_pkg::ADDR_STAT, 16'h786D);
    wr(pmr_pkg::ADDR_CTRL, 16'h1200);
    check("restart", 16'(done), 16'h0);
    wr(pmr_pkg::ADDR_CTRL, 16'h1000);
    lp_pulse(16'h61E0);
    lp_pulse(16'h61E0);
    check("restart_kept", 16'(done), 16'h1);
    wr(pmr_pkg::ADDR_CTRL, 16'h0000);
    check("man_speed", 16'(spd), 16'h0);
    check("man_dup", 16'(dup), 16'h0);
    wr(pmr_pkg::ADDR_CTRL, 16'h0200);
    rd("restart_off", pmr_pkg::ADDR_CTRL, 16'h0000);
    wr(pmr_pkg::ADDR_CTRL, 16'h2100);
    check("man_100f", 16'({spd, dup}), 16'h3);
    wr(pmr_pkg::ADDR_CTRL, 16'h6100);
    check("loop", 16'({loop_o, dead}), 16'h3);
    repeat (60) @(negedge mclk);
    check("dead_end", 16'(dead), 16'h0);
    wr(pmr_pkg::ADDR_CTRL, 16'h6900);
    check("pdn", 16'(pdn), 16'h1);
    rd("ctrl_pdn", pmr_pkg::ADDR_CTRL, 16'h6900);
    wr(pmr_pkg::ADDR_ADV, 16'h0021);
    wr(pmr_pkg::ADDR_CTRL, 16'h8000);
    repeat (20) @(negedge mclk);
    check("srst_out", 16'({loop_o, pdn}), 16'h0);
    rd("ctrl_srst", pmr_pkg::ADDR_CTRL, 16'h1000, 16'hDE00);
    rd("adv_srst", pmr_pkg::ADDR_ADV, 16'h01E1);
    wrap_up();
  end

  // A clean run takes about eleven thousand cycles; thirty thousand means a hang
  initial begin
    #(1_500_000);
    n_fail++;
    wrap_up();
  end
endmodule
